/* File: bench/mcsr_sense_model.sv */
// Partner model: sensor front end feeding live conditions and power status
module mcsr_sense_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [6:0] ev_cond,
   input wire logic ev_timer,
   input wire logic [7:0] ev_second,
   output logic power_ready,
   output logic [6:0] limit_cond,
   output logic thermal_alarm_pin_timer_over,
   output logic [7:0] second_bank_flags
);
   timeunit 1ns;
   timeprecision 1ps;
   // Power settles late on purpose, so early reads see the ready bit low
   logic [5:0] up_cnt_reg;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         up_cnt_reg <= 6'h00;
         power_ready <= 1'b0;
      end else if (up_cnt_reg != 6'h28) begin
         up_cnt_reg <= up_cnt_reg + 6'h01;
      end else begin
         power_ready <= 1'b1;
      end
      limit_cond <= ev_cond;
      thermal_alarm_pin_timer_over <= ev_timer;
      second_bank_flags <= ev_second;
   end
endmodule : mcsr_sense_model

/* File: bench/tb_mcsr_regs.sv */
// Testbench: register access sequences for the monitor configuration bank
module tb_mcsr_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   mcsr_pkg::mcsr_req_t bus_req = '0;
   logic [7:0] rdata, d1, d2, d3, second_bank_flags;
   logic [7:0] ev_second = 8'h00;
   logic [6:0] limit_cond, limit_flags;
   logic [6:0] ev_cond = 7'h00;
   logic ev_timer = 1'b0;
   logic thermal_pin_mode = 1'b0;
   logic power_ready, thermal_alarm_pin_timer_over, go, lk, ff, wf, sb, bt, s5;
   int err_total = 0;
   int cmp_count = 0;
   always #4 core_clk = ~core_clk;
   mcsr_regs mcsr_regs_inst (.core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
      .power_ready(power_ready), .limit_cond(limit_cond), .thermal_alarm_pin_timer_over(thermal_alarm_pin_timer_over),
      .thermal_pin_mode(thermal_pin_mode), .second_bank_flags(second_bank_flags),
      .pwm1_duty_ceiling(d1), .pwm2_duty_ceiling(d2), .pwm3_duty_ceiling(d3), .monitor_go(go),
      .limits_locked(lk), .fans_full_force(ff), .watts_reporting_flag(wf), .spinup_pulse_bypass(sb),
      .bus_timeout_ctl(bt), .supply_five_volt(s5), .limit_flags(limit_flags));
   mcsr_sense_model mcsr_sense_model_inst (.core_clk(core_clk), .rst(rst), .ev_cond(ev_cond),
      .ev_timer(ev_timer), .ev_second(ev_second), .power_ready(power_ready), .limit_cond(limit_cond),
      .thermal_alarm_pin_timer_over(thermal_alarm_pin_timer_over), .second_bank_flags(second_bank_flags));
   task automatic stop_test();
      if (err_total == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
   endtask : wr
   // Data is sampled only in the one cycle where it stands
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd
   task automatic pulse(input logic [6:0] c, input logic t);
      @(posedge core_clk);
      ev_cond <= c;
      ev_timer <= t;
      repeat (3) @(posedge core_clk);
      ev_cond <= 7'h00;
      ev_timer <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask : pulse
   initial begin
      #20000 err_total++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      rd(mcsr_pkg::OFS_CFG, mcsr_pkg::RST_CFG);
      rd(mcsr_pkg::OFS_DUTY1, mcsr_pkg::RST_DUTY);
      rd(mcsr_pkg::OFS_DUTY2, mcsr_pkg::RST_DUTY);
      rd(mcsr_pkg::OFS_DUTY3, mcsr_pkg::RST_DUTY);
      rd(mcsr_pkg::OFS_FLAGS, mcsr_pkg::RST_FLAGS);
      rd(8'h50, mcsr_pkg::RD_UNMAPPED);
      wr(mcsr_pkg::OFS_DUTY1, 8'h80);
      wr(mcsr_pkg::OFS_DUTY2, 8'h81);
      wr(mcsr_pkg::OFS_DUTY3, 8'h82);
      rd(mcsr_pkg::OFS_DUTY1, 8'h80);
      rd(mcsr_pkg::OFS_DUTY2, 8'h81);
      rd(mcsr_pkg::OFS_DUTY3, 8'h82);
      wr(mcsr_pkg::OFS_FLAGS, 8'hFF);
      rd(mcsr_pkg::OFS_FLAGS, 8'h00);
      wr(mcsr_pkg::OFS_CFG, 8'hFC);
      rd(mcsr_pkg::OFS_CFG, 8'hF8);
      chk({s5, bt, sb, wf, ff, 1'b0, lk, go}, 8'hF8);
      repeat (20) @(posedge core_clk);
      rd(mcsr_pkg::OFS_CFG, 8'hFC);
      wr(mcsr_pkg::OFS_CFG, 8'h03);
      rd(mcsr_pkg::OFS_CFG, 8'h07);
      wr(mcsr_pkg::OFS_CFG, 8'hF8);
      rd(mcsr_pkg::OFS_CFG, 8'h2F);
      wr(mcsr_pkg::OFS_DUTY1, 8'h11);
      rd(mcsr_pkg::OFS_DUTY1, 8'h80);
      chk(d1, 8'h80);
      for (int i = 0; i < 7; i++) begin
         pulse(7'h01 << i, 1'b0);
         chk({1'b0, limit_flags}, 8'h01 << i);
         rd(mcsr_pkg::OFS_FLAGS, 8'h01 << i);
         rd(mcsr_pkg::OFS_FLAGS, 8'h00);
      end
      @(posedge core_clk);
      ev_cond <= 7'h01;
      repeat (3) @(posedge core_clk);
      rd(mcsr_pkg::OFS_FLAGS, 8'h01);
      rd(mcsr_pkg::OFS_FLAGS, 8'h01);
      @(posedge core_clk);
      ev_cond <= 7'h00;
      repeat (3) @(posedge core_clk);
      rd(mcsr_pkg::OFS_FLAGS, 8'h01);
      rd(mcsr_pkg::OFS_FLAGS, 8'h00);
      @(posedge core_clk);
      thermal_pin_mode <= 1'b1;
      pulse(7'h00, 1'b1);
      rd(mcsr_pkg::OFS_FLAGS, 8'h08);
      pulse(7'h08, 1'b0);
      rd(mcsr_pkg::OFS_FLAGS, 8'h00);
      @(posedge core_clk);
      ev_second <= 8'h40;
      repeat (3) @(posedge core_clk);
      rd(mcsr_pkg::OFS_FLAGS, 8'h80);
      @(posedge core_clk);
      ev_second <= 8'h00;
      repeat (3) @(posedge core_clk);
      rd(mcsr_pkg::OFS_FLAGS, 8'h00);
      // Only a reset may clear the lock
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      rd(mcsr_pkg::OFS_CFG, mcsr_pkg::RST_CFG);
      rd(mcsr_pkg::OFS_DUTY1, mcsr_pkg::RST_DUTY);
      wr(mcsr_pkg::OFS_DUTY2, 8'h5A);
      rd(mcsr_pkg::OFS_DUTY2, 8'h5A);
      chk(d2, 8'h5A);
      chk(d3, mcsr_pkg::RST_DUTY);
      chk({1'b0, limit_flags}, mcsr_pkg::RST_FLAGS);
      stop_test();
   end
endmodule : tb_mcsr_regs

/* File: verilog/mcsr_pkg.sv */
// Package: register map, resets and bus carrier for the monitor configuration bank
package mcsr_pkg;
   localparam logic [7:0] OFS_DUTY1 = 8'h38;
   localparam logic [7:0] OFS_DUTY2 = 8'h39;
   localparam logic [7:0] OFS_DUTY3 = 8'h3A;
   localparam logic [7:0] OFS_CFG = 8'h40;
   localparam logic [7:0] OFS_FLAGS = 8'h41;
   localparam logic [7:0] RST_DUTY = 8'hFF;
   localparam logic [7:0] RST_CFG = 8'h01;
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   localparam int BIT_GO = 0;
   localparam int BIT_LOCK = 1;
   localparam int BIT_RDY = 2;
   localparam int BIT_FULL = 3;
   localparam int BIT_WATTS = 4;
   localparam int BIT_SPIN = 5;
   localparam int BIT_TMO = 6;
   localparam int BIT_SCALE = 7;
   localparam int BIT_SUMMARY = 7;
   localparam int BIT_FIVE = 3;
   // Lockable configuration bits: go, lock, watts, timeout, scale
   localparam logic [7:0] CFG_LOCK_MASK = 8'hD3;
   // Bits never frozen: full speed, spin-up bypass
   localparam logic [7:0] CFG_FREE_MASK = 8'h28;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } mcsr_req_t;
endpackage : mcsr_pkg

/* File: verilog/mcsr_regs.sv */
// Module: duty ceilings, main configuration and first limit event flags
//
// Implementation choice: the address-and-strobe port.
module mcsr_regs (
   input wire logic core_clk,
   input wire logic rst,
   input wire mcsr_pkg::mcsr_req_t bus_req,
   output logic [7:0] rdata,
   input wire logic power_ready,
   input wire logic [6:0] limit_cond,
   input wire logic thermal_alarm_pin_timer_over,
   input wire logic thermal_pin_mode,
   input wire logic [7:0] second_bank_flags,
   output logic [7:0] pwm1_duty_ceiling,
   output logic [7:0] pwm2_duty_ceiling,
   output logic [7:0] pwm3_duty_ceiling,
   output logic monitor_go,
   output logic limits_locked,
   output logic fans_full_force,
   output logic watts_reporting_flag,
   output logic spinup_pulse_bypass,
   output logic bus_timeout_ctl,
   output logic supply_five_volt,
   output logic [6:0] limit_flags
);
   logic [7:0] duty_reg [3];
   logic [7:0] cfg_reg;
   logic rdy_reg;
   logic [6:0] flags_reg;
   logic [6:0] flags_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [7:0] cfg_next;
   logic [7:0] cfg_wmask;
   logic [6:0] cond;
   logic [7:0] cfg_view;
   logic sel_cfg;
   logic sel_flags;
   logic wr_cfg;
   logic rd_flags;
   logic second_bank_summary;
   logic [2:0] wr_duty;

   assign sel_cfg = bus_req.addr == mcsr_pkg::OFS_CFG;
   assign sel_flags = bus_req.addr == mcsr_pkg::OFS_FLAGS;
   assign wr_cfg = bus_req.wr && sel_cfg;
   assign rd_flags = bus_req.rd && sel_flags;
   // Lock freezes the duty ceilings
   assign wr_duty[0] = bus_req.wr && !cfg_reg[mcsr_pkg::BIT_LOCK] && bus_req.addr == mcsr_pkg::OFS_DUTY1;
   assign wr_duty[1] = bus_req.wr && !cfg_reg[mcsr_pkg::BIT_LOCK] && bus_req.addr == mcsr_pkg::OFS_DUTY2;
   assign wr_duty[2] = bus_req.wr && !cfg_reg[mcsr_pkg::BIT_LOCK] && bus_req.addr == mcsr_pkg::OFS_DUTY3;

   // Locked: only the free bits take a write; go and lock are then frozen too
   assign cfg_wmask = cfg_reg[mcsr_pkg::BIT_LOCK] ? mcsr_pkg::CFG_FREE_MASK
                      : (mcsr_pkg::CFG_FREE_MASK | mcsr_pkg::CFG_LOCK_MASK);
   // Lock only ever gets set by a write, never cleared by one (only reset clears it): write-once
   assign cfg_next = wr_cfg ? ((cfg_reg & ~cfg_wmask) | (bus_req.wdata & cfg_wmask)
                               | (cfg_reg & (8'h01 << mcsr_pkg::BIT_LOCK))) : cfg_reg;

   // Bit 3 source depends on how its pin is configured
   assign cond = {limit_cond[6:4],
                  thermal_pin_mode ? thermal_alarm_pin_timer_over : limit_cond[mcsr_pkg::BIT_FIVE],
                  limit_cond[2:0]};
   // Set wins over the read clear; a flag stays while its condition persists
   assign flags_next = cond | (flags_reg & ~({7{rd_flags}} & ~cond));
   assign second_bank_summary = |second_bank_flags;

   assign cfg_view = {cfg_reg[7:3], rdy_reg, cfg_reg[1:0]};
   // Read data taken from the pre-clear flag value
   assign rdata_next = !bus_req.rd ? 8'h00
                     : bus_req.addr == mcsr_pkg::OFS_DUTY1 ? duty_reg[0]
                     : bus_req.addr == mcsr_pkg::OFS_DUTY2 ? duty_reg[1]
                     : bus_req.addr == mcsr_pkg::OFS_DUTY3 ? duty_reg[2]
                     : sel_cfg ? cfg_view
                     : sel_flags ? {second_bank_summary, flags_reg}
                     : mcsr_pkg::RD_UNMAPPED;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         duty_reg[0] <= mcsr_pkg::RST_DUTY;
         duty_reg[1] <= mcsr_pkg::RST_DUTY;
         duty_reg[2] <= mcsr_pkg::RST_DUTY;
      end else begin
         if (wr_duty[0]) begin
            duty_reg[0] <= bus_req.wdata;
         end
         if (wr_duty[1]) begin
            duty_reg[1] <= bus_req.wdata;
         end
         if (wr_duty[2]) begin
            duty_reg[2] <= bus_req.wdata;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_reg <= mcsr_pkg::RST_CFG;
         rdy_reg <= 1'b0;
         flags_reg <= mcsr_pkg::RST_FLAGS[6:0];
         rdata_reg <= 8'h00;
      end else begin
         cfg_reg <= cfg_next;
         rdy_reg <= power_ready;
         flags_reg <= flags_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;
   assign pwm1_duty_ceiling = duty_reg[0];
   assign pwm2_duty_ceiling = duty_reg[1];
   assign pwm3_duty_ceiling = duty_reg[2];
   // Low go selects default limits downstream; programmed values stay put here
   assign monitor_go = cfg_reg[mcsr_pkg::BIT_GO];
   assign limits_locked = cfg_reg[mcsr_pkg::BIT_LOCK];
   assign fans_full_force = cfg_reg[mcsr_pkg::BIT_FULL];
   assign watts_reporting_flag = cfg_reg[mcsr_pkg::BIT_WATTS];
   assign spinup_pulse_bypass = cfg_reg[mcsr_pkg::BIT_SPIN];
   assign bus_timeout_ctl = cfg_reg[mcsr_pkg::BIT_TMO];
   assign supply_five_volt = cfg_reg[mcsr_pkg::BIT_SCALE];
   assign limit_flags = flags_reg;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_locked_duty_wr;
      limits_locked && bus_req.wr && bus_req.addr == mcsr_pkg::OFS_DUTY1;
   endsequence

   sequence s_flag_read;
      bus_req.rd && bus_req.addr == mcsr_pkg::OFS_FLAGS;
   endsequence

   a_duty_lock_hold: assert property (s_locked_duty_wr |=> $stable(pwm1_duty_ceiling))
      else $error("duty ceiling changed while locked");
   a_lock_sticky: assert property (limits_locked |=> limits_locked [*3])
      else $error("lock bit cleared");
   a_go_frozen: assert property (limits_locked && wr_cfg |=> $stable(monitor_go))
      else $error("monitor go changed while locked");
   a_force_free_write: assert property (wr_cfg |=> fans_full_force == $past(bus_req.wdata[mcsr_pkg::BIT_FULL]))
      else $error("full force write lost");
   a_ready_follow: assert property (##1 rdy_reg == $past(power_ready))
      else $error("ready bit does not follow power state");
   a_cfg_reset_value: assert property ($past(rst) |-> cfg_reg == mcsr_pkg::RST_CFG)
      else $error("configuration reset value wrong");
   a_duty_reset_value: assert property ($past(rst) |-> pwm3_duty_ceiling == mcsr_pkg::RST_DUTY)
      else $error("duty ceiling reset value wrong");
   a_flag_latch_set: assert property (##1 (flags_reg & $past(cond)) == $past(cond))
      else $error("limit flag failed to latch");
   a_flag_held_cond: assert property (s_flag_read ##0 (flags_reg[0] && cond[0]) |=> flags_reg[0])
      else $error("flag cleared while condition present");
   a_flag_clear_read: assert property (s_flag_read ##0 (!cond[5]) |=> flags_reg[5] == $past(cond[5]))
      else $error("flag not cleared by read");
   a_summary_read: assert property (s_flag_read |=> rdata[7] == $past(|second_bank_flags))
      else $error("summary bit wrong");
   a_read_preclear: assert property (s_flag_read |=> rdata[6:0] == $past(flags_reg))
      else $error("read missed set flag");
   a_thermal_alarm_pin_select: assert property (thermal_pin_mode && thermal_alarm_pin_timer_over |=> flags_reg[3])
      else $error("thermal timer flag missing");
   a_flags_reset_zero: assert property ($past(rst) |-> flags_reg == 7'h00)
      else $error("flags not zero after reset");
   a_scale_lock: assert property (limits_locked && wr_cfg |=> $stable(supply_five_volt) && $stable(bus_timeout_ctl))
      else $error("lockable bit changed while locked");

   // Write, hold and read checks for each register
   sequence s_free_duty1_wr;
      !limits_locked && bus_req.wr && bus_req.addr == mcsr_pkg::OFS_DUTY1;
   endsequence

   sequence s_free_duty2_wr;
      !limits_locked && bus_req.wr && bus_req.addr == mcsr_pkg::OFS_DUTY2;
   endsequence

   sequence s_free_duty3_wr;
      !limits_locked && bus_req.wr && bus_req.addr == mcsr_pkg::OFS_DUTY3;
   endsequence

   sequence s_locked_duty2_wr;
      limits_locked && bus_req.wr && bus_req.addr == mcsr_pkg::OFS_DUTY2;
   endsequence

   sequence s_locked_duty3_wr;
      limits_locked && bus_req.wr && bus_req.addr == mcsr_pkg::OFS_DUTY3;
   endsequence

   sequence s_free_cfg_wr;
      !limits_locked && wr_cfg;
   endsequence

   sequence s_locked_cfg_wr;
      limits_locked && wr_cfg;
   endsequence

   sequence s_duty1_read;
      bus_req.rd && bus_req.addr == mcsr_pkg::OFS_DUTY1;
   endsequence

   sequence s_duty2_read;
      bus_req.rd && bus_req.addr == mcsr_pkg::OFS_DUTY2;
   endsequence

   sequence s_duty3_read;
      bus_req.rd && bus_req.addr == mcsr_pkg::OFS_DUTY3;
   endsequence

   sequence s_cfg_read;
      bus_req.rd && sel_cfg;
   endsequence

   sequence s_no_read;
      !bus_req.rd;
   endsequence

   sequence s_flags_write;
      bus_req.wr && sel_flags;
   endsequence

   a_duty1_write_land: assert property (s_free_duty1_wr |=> pwm1_duty_ceiling == $past(bus_req.wdata))
      else $error("duty ceiling 1 write lost");

   a_duty2_write_land: assert property (s_free_duty2_wr |=> pwm2_duty_ceiling == $past(bus_req.wdata))
      else $error("duty ceiling 2 write lost");

   a_duty3_write_land: assert property (s_free_duty3_wr |=> pwm3_duty_ceiling == $past(bus_req.wdata))
      else $error("duty ceiling 3 write lost");

   a_duty2_lock_hold: assert property (s_locked_duty2_wr |=> $stable(pwm2_duty_ceiling))
      else $error("duty ceiling 2 changed while locked");

   a_duty3_lock_hold: assert property (s_locked_duty3_wr |=> $stable(pwm3_duty_ceiling))
      else $error("duty ceiling 3 changed while locked");

   a_duty1_read_data: assert property (s_duty1_read |=> rdata == $past(pwm1_duty_ceiling))
      else $error("duty ceiling 1 read wrong");

   a_duty2_read_data: assert property (s_duty2_read |=> rdata == $past(pwm2_duty_ceiling))
      else $error("duty ceiling 2 read wrong");

   a_duty3_read_data: assert property (s_duty3_read |=> rdata == $past(pwm3_duty_ceiling))
      else $error("duty ceiling 3 read wrong");

   a_cfg_read_data: assert property (s_cfg_read |=> rdata[2:0] == $past({rdy_reg, limits_locked, monitor_go}))
      else $error("configuration read wrong");

   a_ready_not_stored: assert property (!cfg_reg[mcsr_pkg::BIT_RDY])
      else $error("ready bit stored from a write");

   a_go_write_land: assert property (s_free_cfg_wr |=> monitor_go == $past(bus_req.wdata[mcsr_pkg::BIT_GO]))
      else $error("monitor go write lost");

   a_lock_write_set: assert property (s_free_cfg_wr ##0 bus_req.wdata[mcsr_pkg::BIT_LOCK] |=> limits_locked)
      else $error("lock write lost");

   a_watts_write_land: assert property (s_free_cfg_wr |=> watts_reporting_flag == $past(bus_req.wdata[4]))
      else $error("watts flag write lost");

   a_timeout_write_land: assert property (s_free_cfg_wr |=> bus_timeout_ctl == $past(bus_req.wdata[6]))
      else $error("bus timeout write lost");

   a_scale_write_land: assert property (s_free_cfg_wr |=> supply_five_volt == $past(bus_req.wdata[7]))
      else $error("supply scale write lost");

   a_spin_free_write: assert property (wr_cfg |=> spinup_pulse_bypass == $past(bus_req.wdata[5]))
      else $error("spin-up bypass write lost");

   a_watts_lock: assert property (s_locked_cfg_wr |=> $stable(watts_reporting_flag))
      else $error("watts flag changed while locked");

   a_force_locked_write: assert property (s_locked_cfg_wr |=> fans_full_force == $past(bus_req.wdata[3]))
      else $error("full force write lost while locked");

   a_cfg_hold_idle: assert property (!wr_cfg |=> $stable(cfg_reg))
      else $error("configuration changed without a write");

   a_duty_hold_idle: assert property (!bus_req.wr |=> $stable({pwm1_duty_ceiling, pwm2_duty_ceiling, pwm3_duty_ceiling}))
      else $error("duty ceiling changed without a write");

   a_rdata_idle_zero: assert property (s_no_read |=> rdata == 8'h00)
      else $error("read data not zero when idle");

   a_flags_write_ignored: assert property (s_flags_write |=> flags_reg == ($past(flags_reg) | $past(cond)))
      else $error("flag register took a write");

   a_ready_low_reset: assert property ($past(rst) |-> !rdy_reg)
      else $error("ready bit set after reset");

   a_rdata_reset_zero: assert property ($past(rst) |-> rdata == 8'h00)
      else $error("read data not zero after reset");

   a_duty12_reset: assert property ($past(rst) |-> pwm1_duty_ceiling == 8'hFF && pwm2_duty_ceiling == 8'hFF)
      else $error("duty ceiling reset value wrong");

   // Per-flag checks: latch, set wins over the read clear, read clear without a condition
   a_flag0_set: assert property (cond[0] |=> flags_reg[0])
      else $error("flag 0 did not latch");

   a_flag1_set: assert property (cond[1] |=> flags_reg[1])
      else $error("flag 1 did not latch");

   a_flag2_set: assert property (cond[2] |=> flags_reg[2])
      else $error("flag 2 did not latch");

   a_flag3_set: assert property (cond[3] |=> flags_reg[3])
      else $error("flag 3 did not latch");

   a_flag4_set: assert property (cond[4] |=> flags_reg[4])
      else $error("flag 4 did not latch");

   a_flag5_set: assert property (cond[5] |=> flags_reg[5])
      else $error("flag 5 did not latch");

   a_flag6_set: assert property (cond[6] |=> flags_reg[6])
      else $error("flag 6 did not latch");

   a_flag1_held: assert property (s_flag_read ##0 cond[1] |=> flags_reg[1])
      else $error("flag 1 cleared while condition present");

   a_flag2_held: assert property (s_flag_read ##0 cond[2] |=> flags_reg[2])
      else $error("flag 2 cleared while condition present");

   a_flag3_held: assert property (s_flag_read ##0 cond[3] |=> flags_reg[3])
      else $error("flag 3 cleared while condition present");

   a_flag4_held: assert property (s_flag_read ##0 cond[4] |=> flags_reg[4])
      else $error("flag 4 cleared while condition present");

   a_flag5_held: assert property (s_flag_read ##0 cond[5] |=> flags_reg[5])
      else $error("flag 5 cleared while condition present");

   a_flag6_held: assert property (s_flag_read ##0 cond[6] |=> flags_reg[6])
      else $error("flag 6 cleared while condition present");

   a_flag0_clear: assert property (s_flag_read ##0 !cond[0] |=> !flags_reg[0])
      else $error("flag 0 not cleared by read");

   a_flag1_clear: assert property (s_flag_read ##0 !cond[1] |=> !flags_reg[1])
      else $error("flag 1 not cleared by read");

   a_flag2_clear: assert property (s_flag_read ##0 !cond[2] |=> !flags_reg[2])
      else $error("flag 2 not cleared by read");

   a_flag3_clear: assert property (s_flag_read ##0 !cond[3] |=> !flags_reg[3])
      else $error("flag 3 not cleared by read");

   a_flag4_clear: assert property (s_flag_read ##0 !cond[4] |=> !flags_reg[4])
      else $error("flag 4 not cleared by read");

   a_flag6_clear: assert property (s_flag_read ##0 !cond[6] |=> !flags_reg[6])
      else $error("flag 6 not cleared by read");

   a_flag3_voltage_src: assert property (!thermal_pin_mode && limit_cond[3] |=> flags_reg[3])
      else $error("5 V flag missing in voltage mode");
endmodule : mcsr_regs
